// >>> adc_setup_pkg.sv
// Shared constants, codes and carriers for the converter setup and sampling control.
package adc_setup_pkg;

	localparam int SETUP_W         = 12;
	localparam int FRAME_BITS      = 16;
	localparam int CMD_BITS        = 4;
	localparam int EDGE_W          = 5;
	localparam int SHORT_CONV_EDGE = 16;
	localparam int LONG_CONV_EDGE  = 28;
	localparam int CONV_PERIODS    = 14;
	localparam int CONV_CNT_W      = 10;

	localparam int SYS_CLK_MHZ      = 200;
	localparam int OSC_CONV_TIME_NS = 3860;
	localparam int OSC_CONV_CYC     = (OSC_CONV_TIME_NS * SYS_CLK_MHZ) / 1000;

	localparam logic [3:0] CMD_CH_LAST    = 4'h7;
	localparam logic [3:0] CMD_SW_PD      = 4'h8;
	localparam logic [3:0] CMD_READ_SETUP = 4'h9;
	localparam logic [3:0] CMD_WR_SETUP   = 4'hA;
	localparam logic [3:0] CMD_TEST_MID   = 4'hB;
	localparam logic [3:0] CMD_TEST_HIGH  = 4'hD;

	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_REPEAT = 2'h1;
	localparam logic [1:0] MODE_SWEEP  = 2'h2;
	localparam logic [1:0] MODE_RSWEEP = 2'h3;

	localparam logic [1:0] CCLK_OSC  = 2'h0;
	localparam logic [1:0] CCLK_SCLK = 2'h1;
	localparam logic [1:0] CCLK_DIV4 = 2'h2;
	localparam logic [1:0] CCLK_DIV2 = 2'h3;

	localparam logic [SETUP_W-1:0] SETUP_RESET = 12'h000;

	typedef struct packed {
		logic       ref_internal;
		logic       ref_2v;
		logic       long_sample;
		logic [1:0] conv_clk;
		logic [1:0] mode;
		logic [1:0] sweep_order;
		logic       status_eoc;
		logic [1:0] threshold;
	} setup_s;

	typedef struct packed {
		logic chip_select_n;
		logic sclk;
		logic sdi;
		logic frame_sync;
		logic sample_start_pin_n;
	} pins_s;

	// Select high, serial clock low, data low, frame sync high, start pin high.
	localparam pins_s PINS_IDLE = 5'h13;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_CONVERT = 2'b10,
		ST_PEND    = 2'b11
	} ctl_state_e;

endpackage

// >>> pin_sync3.sv
// Three-stage synchroniser whose output follows once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] stable_q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	if (W < 1)
	begin : g_width_check
		$error("pin_sync3 needs a width of at least one");
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_q     <= RST_VAL;
			s2_q     <= RST_VAL;
			s3_q     <= RST_VAL;
			stable_q <= RST_VAL;
		end
		else
		begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++)
			begin
				if (s2_q[i] == s3_q[i])
					stable_q[i] <= s3_q[i];
			end
		end
	end

endmodule
`default_nettype wire

// >>> adc_config_sampling_control.sv
// Setup register, serial command decode and sample/convert sequencing of the converter.
//
// Behaviour
// - One 12-bit setup register holds all settings, kept through any power-down.
// - A setup write is 16 bits; serial clock may pause after eight.
// - Bit 11 picks reference: 0 external, 1 internal.
// - Bit 10 picks internal reference level: 0 is 4 V, 1 is 2 V.
// - Bit 9 picks sampling length: 12 or 24 serial clocks.
// - Bits 8..7 pick conversion clock: oscillator, SCLK, SCLK/4, SCLK/2.
// - Bits 6..5 pick mode; single shot bypasses FIFO and ignores threshold.
// - Bits 4..3 pick the automatic sweep order of inputs.
// - Sweep order matters only in sweep and repeat-sweep modes.
// - Bit 2 makes the status pin interrupt (0) or end-of-conversion (1).
// - Bits 1..0 set FIFO threshold level 7, 5, 3 or 1.
// - Normal sampling begins after four bits that decode as a conversion command.
// - With select high, start pin fall samples and its rise converts.
// - Start pin lowered inside a select cycle samples only once select is high.
// - After extended conversion the stored result shifts out on the next read.
// - Extended sampling ends after two select falls with start pin high.
// - Normal conversion starts after 16 or 28 serial clocks, command included.
// - SCLK-derived conversion lasts 14 conversion-clock periods of divider 1, 2, 4.
// - Start pin triggers in non-single modes only with internal reference.
// - Channel 0 filler does not trigger in extended mode; other commands like power-down still act.
// - Setup write is code 1010b followed by 12 setup bits.
// - Frame sync fall starts a cycle when used, else select fall.
// - Codes 1011b to 1101b select internal test inputs as conversion commands.
`timescale 1ns/1ps
`default_nettype none
module adc_config_sampling_control
	import adc_setup_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rstn,
	input  wire logic               chip_select_n,
	input  wire logic               sclk,
	input  wire logic               sdi,
	input  wire logic               frame_sync,
	input  wire logic               sample_start_pin_n,
	input  wire logic [SETUP_W-1:0] conv_result,
	output var  setup_s             setup_q,
	output var  logic [3:0]         channel_q,
	output var  logic               sampling_q,
	output var  logic               converting_q,
	output var  logic               conv_start_q,
	output var  logic               power_down_q,
	output var  logic               ext_mode_q,
	output var  logic [1:0]         sweep_order_q,
	output var  logic [2:0]         fifo_level_q,
	output var  logic               fifo_bypass_q,
	output var  logic               status_pin_q,
	output var  logic               sdo_q,
	output var  logic               sdo_oe_n_q
);

	pins_s               pins;
	pins_s               prev_q;
	logic [EDGE_W-1:0]   bit_cnt_q;
	logic [FRAME_BITS-1:0] rx_q;
	logic [FRAME_BITS-1:0] rx_next;
	logic [FRAME_BITS-1:0] tx_q;
	logic [3:0]          cmd_q;
	logic [SETUP_W-1:0]  result_q;
	logic [CONV_CNT_W-1:0] conv_cnt_q;
	logic [CONV_CNT_W-1:0] conv_last;
	logic [1:0]          ext_cs_cnt_q;
	logic                int_pend_q;
	ctl_state_e          state_q;
	ctl_state_e          state_d;

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic start_fall;
	logic start_rise;
	logic cycle_start;
	logic shift_in;
	logic cmd_fire;
	logic wr_fire;
	logic conv_cmd;
	logic ext_allowed;
	logic norm_go;
	logic conv_done;
	logic [3:0] new_cmd;

	pin_sync3 #(
		.W       (5),
		.RST_VAL (PINS_IDLE)
	) u_sync (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.async_in ({chip_select_n, sclk, sdi, frame_sync, sample_start_pin_n}),
		.stable_q (pins)
	);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			prev_q <= PINS_IDLE;
		else
			prev_q <= pins;
	end

	assign sclk_rise   = pins.sclk & ~prev_q.sclk;
	assign sclk_fall   = ~pins.sclk & prev_q.sclk;
	assign cs_fall     = ~pins.chip_select_n & prev_q.chip_select_n;
	assign cs_rise     = pins.chip_select_n & ~prev_q.chip_select_n;
	assign start_fall  = ~pins.sample_start_pin_n & prev_q.sample_start_pin_n;
	assign start_rise  = pins.sample_start_pin_n & ~prev_q.sample_start_pin_n;
	// A frame-sync fall with select low restarts the frame; a select fall does so only when frame sync idles high.
	assign cycle_start = (cs_fall & pins.frame_sync)
		| (~pins.frame_sync & prev_q.frame_sync & ~pins.chip_select_n);
	assign shift_in    = sclk_rise & ~pins.chip_select_n & ~cycle_start;
	assign rx_next     = {rx_q[FRAME_BITS-2:0], pins.sdi};
	assign new_cmd     = rx_next[3:0];
	assign cmd_fire    = shift_in & (bit_cnt_q == EDGE_W'(CMD_BITS - 1));
	assign wr_fire     = shift_in & (bit_cnt_q == EDGE_W'(FRAME_BITS - 1)) & (cmd_q == CMD_WR_SETUP);
	assign conv_cmd    = (new_cmd <= CMD_CH_LAST)
		| ((new_cmd >= CMD_TEST_MID) & (new_cmd <= CMD_TEST_HIGH));
	assign ext_allowed = (setup_q.mode == MODE_SINGLE) | setup_q.ref_internal;

	// Serial frame: bit counter runs past 16 so long sampling can reach edge 28.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bit_cnt_q <= '0;
			rx_q      <= '0;
			cmd_q     <= '0;
		end
		else if (cycle_start)
			bit_cnt_q <= '0;
		else if (shift_in)
		begin
			rx_q <= rx_next;
			if (bit_cnt_q != '1)
				bit_cnt_q <= bit_cnt_q + EDGE_W'(1);
			if (cmd_fire)
				cmd_q <= new_cmd;
		end
	end

	// Setup register; power-down never touches it.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			setup_q <= setup_s'(SETUP_RESET);
		else if (wr_fire)
			setup_q <= setup_s'(rx_next[SETUP_W-1:0]);
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			channel_q    <= '0;
			power_down_q <= 1'b0;
		end
		else if (cmd_fire)
		begin
			if (new_cmd == CMD_SW_PD)
				power_down_q <= 1'b1;
			else if (conv_cmd)
			begin
				power_down_q <= 1'b0;
				channel_q    <= new_cmd;
			end
		end
	end

	// Decoded view of the setup fields for the analog core and the FIFO.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sweep_order_q <= '0;
			fifo_level_q  <= '0;
			fifo_bypass_q <= 1'b1;
		end
		else
		begin
			sweep_order_q <= setup_q.mode[1] ? setup_q.sweep_order : 2'h0;
			fifo_bypass_q <= (setup_q.mode == MODE_SINGLE);
			fifo_level_q  <= (setup_q.mode == MODE_SINGLE) ? 3'h0 : 3'(4'h7 - {1'b0, setup_q.threshold, 1'b0});
		end
	end

	// Conversion length: 14 periods of the divided serial clock, or the oscillator time.
	always_comb
	begin
		case (setup_q.conv_clk)
			CCLK_SCLK: conv_last = CONV_CNT_W'(CONV_PERIODS - 1);
			CCLK_DIV2: conv_last = CONV_CNT_W'(CONV_PERIODS * 2 - 1);
			CCLK_DIV4: conv_last = CONV_CNT_W'(CONV_PERIODS * 4 - 1);
			default:   conv_last = CONV_CNT_W'(OSC_CONV_CYC - 1);
		endcase
	end

	assign norm_go   = (state_q == ST_SAMPLE) & ~ext_mode_q & shift_in
		& (bit_cnt_q == (setup_q.long_sample ? EDGE_W'(LONG_CONV_EDGE - 1)
		: EDGE_W'(SHORT_CONV_EDGE - 1)));
	assign conv_done = (state_q == ST_CONVERT) & (conv_cnt_q == conv_last)
		& ((setup_q.conv_clk == CCLK_OSC) | sclk_rise);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (start_fall & ext_allowed)
					state_d = pins.chip_select_n ? ST_SAMPLE : ST_PEND;
				else if (cmd_fire & conv_cmd & ~ext_mode_q)
					state_d = ST_SAMPLE;
			end
			ST_PEND:
			begin
				if (pins.sample_start_pin_n)
					state_d = ST_IDLE;
				else if (pins.chip_select_n)
					state_d = ST_SAMPLE;
			end
			ST_SAMPLE:
			begin
				if (ext_mode_q ? start_rise : norm_go)
					state_d = ST_CONVERT;
			end
			ST_CONVERT:
			begin
				if (conv_done)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q      <= ST_IDLE;
			sampling_q   <= 1'b0;
			converting_q <= 1'b0;
			conv_start_q <= 1'b0;
		end
		else
		begin
			state_q      <= state_d;
			sampling_q   <= (state_d == ST_SAMPLE);
			converting_q <= (state_d == ST_CONVERT);
			conv_start_q <= (state_d == ST_CONVERT) & (state_q != ST_CONVERT);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			conv_cnt_q <= '0;
		else if (state_q != ST_CONVERT)
			conv_cnt_q <= '0;
		else if ((setup_q.conv_clk == CCLK_OSC) | sclk_rise)
			conv_cnt_q <= conv_cnt_q + CONV_CNT_W'(1);
	end

	// Extended mode is left after two select falls seen with the start pin high.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ext_mode_q   <= 1'b0;
			ext_cs_cnt_q <= '0;
		end
		else if ((state_q == ST_IDLE) & start_fall & ext_allowed)
		begin
			ext_mode_q   <= 1'b1;
			ext_cs_cnt_q <= '0;
		end
		else if (ext_mode_q & cs_fall & pins.sample_start_pin_n)
		begin
			if (ext_cs_cnt_q == 2'h1)
			begin
				ext_mode_q   <= 1'b0;
				ext_cs_cnt_q <= '0;
			end
			else
				ext_cs_cnt_q <= ext_cs_cnt_q + 2'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			result_q <= '0;
		else if (conv_done)
			result_q <= conv_result;
	end

	// Interrupt is low from conversion end until the next cycle; end-of-conversion is low while busy.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			int_pend_q   <= 1'b0;
			status_pin_q <= 1'b1;
		end
		else
		begin
			if (conv_done)
				int_pend_q <= 1'b1;
			else if (cycle_start)
				int_pend_q <= 1'b0;
			status_pin_q <= setup_q.status_eoc ? (state_q != ST_CONVERT) : ~int_pend_q;
		end
	end

	// Output shifter: result at cycle start, setup after a read-setup command, MSB first.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_q       <= '0;
			sdo_q      <= 1'b0;
			sdo_oe_n_q <= 1'b1;
		end
		else
		begin
			sdo_oe_n_q <= pins.chip_select_n;
			if (cycle_start)
			begin
				sdo_q <= result_q[SETUP_W-1];
				tx_q  <= {result_q[SETUP_W-2:0], 5'h00};
			end
			else if (cmd_fire & (new_cmd == CMD_READ_SETUP))
				tx_q <= {setup_q, 4'h0};
			else if (sclk_fall & ~pins.chip_select_n)
			begin
				sdo_q <= tx_q[FRAME_BITS-1];
				tx_q  <= {tx_q[FRAME_BITS-2:0], 1'b0};
			end
		end
	end

	property p_setup_only_on_write;
		@(posedge sys_clk) disable iff (!rstn)
		!$stable(setup_q) |-> $past(wr_fire);
	endproperty
	a_setup_only_on_write: assert property (p_setup_only_on_write) else $error("setup changed without a full write");

	property p_norm_convert;
		@(posedge sys_clk) disable iff (!rstn)
		norm_go |=> converting_q && conv_start_q
			&& bit_cnt_q == (setup_q.long_sample ? EDGE_W'(LONG_CONV_EDGE) : EDGE_W'(SHORT_CONV_EDGE));
	endproperty
	a_norm_convert: assert property (p_norm_convert) else $error("normal conversion did not start on edge 16 or 28");

	property p_ext_convert;
		@(posedge sys_clk) disable iff (!rstn)
		(state_q == ST_SAMPLE && ext_mode_q && start_rise) |=> converting_q;
	endproperty
	a_ext_convert: assert property (p_ext_convert) else $error("start pin rise did not start conversion");

	property p_sclk_conv_len;
		@(posedge sys_clk) disable iff (!rstn)
		(conv_done && setup_q.conv_clk == CCLK_DIV2) |-> conv_cnt_q == CONV_CNT_W'(CONV_PERIODS * 2 - 1);
	endproperty
	a_sclk_conv_len: assert property (p_sclk_conv_len) else $error("divided conversion length wrong");

	property p_ext_exit;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(ext_mode_q) |-> $past(ext_cs_cnt_q) == 2'h1 && $past(cs_fall);
	endproperty
	a_ext_exit: assert property (p_ext_exit) else $error("extended mode left early");

	property p_ext_ref;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(ext_mode_q) |-> $past(setup_q.mode) == MODE_SINGLE || $past(setup_q.ref_internal);
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("start pin trigger with external reference");

	property p_pend_waits_cs;
		@(posedge sys_clk) disable iff (!rstn)
		($rose(sampling_q) && ext_mode_q) |-> $past(pins.chip_select_n);
	endproperty
	a_pend_waits_cs: assert property (p_pend_waits_cs) else $error("sampling before select went high");

	property p_norm_needs_cmd;
		@(posedge sys_clk) disable iff (!rstn)
		($rose(sampling_q) && !ext_mode_q && state_q != ST_IDLE) |-> $past(cmd_fire && conv_cmd);
	endproperty
	a_norm_needs_cmd: assert property (p_norm_needs_cmd) else $error("sampling without conversion command");

	property p_sweep_gate;
		@(posedge sys_clk) disable iff (!rstn)
		(sweep_order_q != 2'h0) |-> $past(setup_q.mode[1]);
	endproperty
	a_sweep_gate: assert property (p_sweep_gate) else $error("sweep order active outside sweep modes");

	property p_eoc_low;
		@(posedge sys_clk) disable iff (!rstn)
		(setup_q.status_eoc && state_q == ST_CONVERT) ##1 setup_q.status_eoc |-> !status_pin_q;
	endproperty
	a_eoc_low: assert property (p_eoc_low) else $error("end-of-conversion not low while busy");

	c_norm_conv: cover property (@(posedge sys_clk) disable iff (!rstn) norm_go ##[1:1000] conv_done);
	c_ext_exit: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(ext_mode_q));
	c_setup_write: cover property (@(posedge sys_clk) disable iff (!rstn) wr_fire);
	c_pend_sample: cover property (@(posedge sys_clk) disable iff (!rstn) state_q == ST_PEND ##1 state_q == ST_SAMPLE);

endmodule
`default_nettype wire

// >>> adc_host_model.sv
// Host serial port model that drives the converter's select, clock, data and start pins.
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
	input  wire logic sys_clk,
	input  wire logic sdo,
	output var  logic chip_select_n,
	output var  logic sclk,
	output var  logic sdi,
	output var  logic frame_sync,
	output var  logic sample_start_pin_n
);
	int          rise_cnt = 0;
	logic [15:0] rx_q     = 16'h0000;

	initial
	begin
		chip_select_n      = 1'b1;
		sclk               = 1'b0;
		sdi                = 1'b0;
		frame_sync         = 1'b1;
		sample_start_pin_n = 1'b1;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Each clock phase lasts at least four system cycles; sdo is taken just before each rise.
	task automatic frame(input logic [15:0] word, input int nbits, input int extra, input bit pause);
		int i;
		@(posedge sys_clk);
		chip_select_n <= 1'b0;
		rise_cnt      <= 0;
		for (i = 0; i < nbits + extra; i++)
		begin
			sdi <= (i < nbits) ? word[15-i] : 1'b0;
			cyc(8);
			if (pause && i == 8)
				cyc(40);
			rx_q     <= {rx_q[14:0], sdo};
			sclk     <= 1'b1;
			rise_cnt <= rise_cnt + 1;
			cyc(4);
			sclk <= 1'b0;
		end
		cyc(8);
		chip_select_n <= 1'b1;
		sdi           <= ~sdi;
		// Select stays high long enough for the three-stage synchroniser to see the gap.
		cyc(8);
	endtask

	// Frame opened by a frame-sync fall in the same cycle as the select fall.
	task automatic fs_frame(input logic [15:0] word);
		@(posedge sys_clk);
		chip_select_n <= 1'b0;
		frame_sync    <= 1'b0;
		cyc(8);
		frame_sync    <= 1'b1;
		frame(word, 16, 0, 1'b0);
	endtask

	task automatic start_pulse(input int lo);
		@(posedge sys_clk);
		sample_start_pin_n <= 1'b0;
		cyc(lo);
		sample_start_pin_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> adc_config_sampling_control_tb.sv
// Self-checking testbench for the converter setup and sampling control block.
`timescale 1ns/1ps
`default_nettype none
module adc_config_sampling_control_tb;
	import adc_setup_pkg::*;
	localparam logic [11:0] CFG [4] = '{12'h884, 12'h984, 12'hB00, 12'hB04};
	localparam logic [3:0]  CMDS [4] = '{4'h0, CMD_TEST_MID, 4'hC, CMD_TEST_HIGH};
	logic               sys_clk     = 1'b0;
	logic               rstn        = 1'b0;
	logic [SETUP_W-1:0] conv_result = 12'h000;
	setup_s             setup_q;
	logic [3:0]         channel_q;
	logic               sampling_q, converting_q, conv_start_q, power_down_q, ext_mode_q;
	logic [1:0]         sweep_order_q;
	logic [2:0]         fifo_level_q;
	logic               fifo_bypass_q, status_pin_q, sdo_q, sdo_oe_n_q;
	logic               cs_n, sclk, sdi, fs, start_n;
	int                 num_errors = 0;
	int                 n_tests    = 0;
	int                 cycles     = 0;
	int                 samp_cnt   = 0;
	int                 start_rise = 0;
	int                 conv_cyc   = 0;
	logic               conv_prev  = 1'b0;
	logic               samp_prev  = 1'b0;
	logic [11:0]        seen_setup = 12'h000;
	logic [11:0]        cur        = 12'h000;
	logic [31:0]        rng        = 32'h0000003B;
	logic [11:0]        exp_setup[$];
	int                 exp_rise[$];
	int                 exp_len[$];

	always #2.5 sys_clk = ~sys_clk;

	adc_host_model adc_host_model_i (.sys_clk(sys_clk), .sdo(sdo_q), .chip_select_n(cs_n), .sclk(sclk),
		.sdi(sdi), .frame_sync(fs), .sample_start_pin_n(start_n));

	adc_config_sampling_control adc_config_sampling_control_i (.sys_clk(sys_clk), .rstn(rstn),
		.chip_select_n(cs_n), .sclk(sclk), .sdi(sdi), .frame_sync(fs), .sample_start_pin_n(start_n),
		.conv_result(conv_result), .setup_q(setup_q), .channel_q(channel_q), .sampling_q(sampling_q),
		.converting_q(converting_q), .conv_start_q(conv_start_q), .power_down_q(power_down_q),
		.ext_mode_q(ext_mode_q), .sweep_order_q(sweep_order_q), .fifo_level_q(fifo_level_q),
		.fifo_bypass_q(fifo_bypass_q), .status_pin_q(status_pin_q), .sdo_q(sdo_q), .sdo_oe_n_q(sdo_oe_n_q));

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("Checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Takes the oldest note off each queue whenever the matching result shows at the ports.
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			give_verdict();
		end
		if (rstn && setup_q !== seen_setup)
			chk("setup_q", (exp_setup.size() != 0) ? exp_setup.pop_front() : 32'hFFFF, 32'(setup_q));
		seen_setup = setup_q;
		if (sampling_q === 1'b1 && !samp_prev)
		begin
			samp_cnt++;
			if (start_n === 1'b1)
				chk("sample_start_rise", 4, adc_host_model_i.rise_cnt);
		end
		samp_prev = sampling_q;
		if (conv_start_q === 1'b1)
		begin
			start_rise = adc_host_model_i.rise_cnt;
			conv_cyc   = 0;
			chk("conv_start_rise", (exp_rise.size() != 0) ? exp_rise.pop_front() : -1, start_rise);
		end
		conv_cyc++;
		if (conv_prev && converting_q === 1'b0)
		begin
			if (exp_len.size() != 0 && exp_len[0] == 0)
				chk("osc_conv_len", 1, 32'(conv_cyc >= 770 && conv_cyc <= 776));
			else
				chk("conv_len", (exp_len.size() != 0) ? exp_len[0] : -1, adc_host_model_i.rise_cnt - start_rise);
			if (exp_len.size() != 0)
				void'(exp_len.pop_front());
		end
		conv_prev = converting_q;
	end

	task automatic frm(input logic [15:0] w, input int nb, input int ex, input bit pz);
		adc_host_model_i.frame(w, nb, ex, pz);
	endtask

	task automatic wr_setup(input logic [11:0] v, input bit pz);
		if (v !== cur)
			exp_setup.push_back(v);
		cur = v;
		frm({CMD_WR_SETUP, v}, 16, 0, pz);
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic convert(input logic [3:0] cmd);
		int div;
		div = (cur[8:7] == CCLK_SCLK) ? 1 : (cur[8:7] == CCLK_DIV2) ? 2 : 4;
		conv_result <= 12'(rnd());
		exp_rise.push_back(cur[9] ? LONG_CONV_EDGE : SHORT_CONV_EDGE);
		exp_len.push_back(CONV_PERIODS * div);
		frm({cmd, 12'h000}, 16, (cur[9] ? 12 : 0) + CONV_PERIODS * div + 3, 1'b0);
		chk("channel_q", cmd, channel_q);
		chk("status_pin", cur[2], status_pin_q);
	endtask

	initial
	begin
		int          m;
		logic [11:0] v;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk("reset_setup", 0, 32'(setup_q));
		chk("reset_bypass", 1, fifo_bypass_q);
		chk("reset_oe_n", 1, sdo_oe_n_q);
		for (m = 0; m < 8; m++)
		begin
			v      = 12'(rnd());
			v[6:5] = m[1:0];
			wr_setup(v, m[2]);
			chk("fifo_bypass", v[6:5] == MODE_SINGLE, fifo_bypass_q);
			chk("fifo_level", (v[6:5] == MODE_SINGLE) ? 0 : 7 - 2 * v[1:0], fifo_level_q);
			chk("sweep_order", v[6] ? v[4:3] : 2'h0, sweep_order_q);
		end
		chk("no_sampling", 0, samp_cnt);
		frm({CMD_WR_SETUP, ~cur}, 10, 0, 1'b0);
		chk("setup_kept", cur, 32'(setup_q));
		wr_setup(12'h884, 1'b0);
		frm({CMD_READ_SETUP, 12'h000}, 16, 0, 1'b0);
		chk("read_setup", cur, adc_host_model_i.rx_q[11:0]);
		for (m = 0; m < 4; m++)
		begin
			wr_setup(CFG[m], 1'b0);
			convert((m == 0) ? 4'(rnd() % 8) : CMDS[m]);
		end
		m = samp_cnt;
		frm({CMD_SW_PD, 12'h000}, 16, 0, 1'b0);
		chk("power_down", 1, power_down_q);
		chk("pd_no_sampling", m, samp_cnt);
		convert(CMDS[0]);
		chk("power_up", 0, power_down_q);
		wr_setup(12'h804, 1'b0);
		exp_rise.push_back(adc_host_model_i.rise_cnt);
		exp_len.push_back(0);
		conv_result <= 12'(rnd());
		fork
			adc_host_model_i.start_pulse(40);
			begin
				repeat (20) @(posedge sys_clk);
				chk("ext_sampling", 1, sampling_q);
				chk("ext_mode", 1, ext_mode_q);
			end
		join
		repeat (900) @(posedge sys_clk);
		v = conv_result;
		frm({4'hE, 12'h000}, 16, 0, 1'b0);
		chk("ext_result", v, adc_host_model_i.rx_q[15:4]);
		chk("ext_kept", 1, ext_mode_q);
		wr_setup(12'h884, 1'b0);
		chk("ext_left", 0, ext_mode_q);
		wr_setup(12'h804, 1'b0);
		exp_rise.push_back(FRAME_BITS);
		exp_len.push_back(0);
		conv_result <= 12'(rnd());
		fork
			frm({CMD_READ_SETUP, 12'h000}, 16, 0, 1'b0);
			begin
				wait (adc_host_model_i.rise_cnt == 5);
				fork
					adc_host_model_i.start_pulse(300);
				join_none
				repeat (20) @(posedge sys_clk);
				chk("pend_wait", 0, sampling_q);
				chk("sdo_oe_n", 0, sdo_oe_n_q);
			end
		join
		chk("pend_read", cur, adc_host_model_i.rx_q[11:0]);
		chk("pend_sample", 1, sampling_q);
		repeat (1100) @(posedge sys_clk);
		v = conv_result;
		frm({4'hE, 12'h000}, 16, 0, 1'b0);
		chk("pend_result", v, adc_host_model_i.rx_q[15:4]);
		wr_setup(12'h024, 1'b0);
		m = samp_cnt;
		adc_host_model_i.start_pulse(40);
		repeat (20) @(posedge sys_clk);
		chk("ext_refused", m, samp_cnt);
		chk("ext_mode_refused", 0, ext_mode_q);
		cur = 12'h884;
		exp_setup.push_back(cur);
		adc_host_model_i.fs_frame({CMD_WR_SETUP, cur});
		repeat (8) @(posedge sys_clk);
		chk("fs_setup", cur, 32'(setup_q));
		give_verdict();
	end
endmodule
`default_nettype wire
